// File: design/compare_output_timer.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - Writing the run bit to 0 clears the count to zero.
// - Compare data reads return the active compare value, not a pending one.
// - Count value reads return the present count.
// - Writes to the count value register are ignored.
// - While stopped, a compare data write goes into the active compare at once.
// - While running free, pending compare data loads only on overflow.
// - While running with clear on compare 1, pending data loads on a compare 1 hit.
// - A control bit selects clearing the count on a compare 1 hit, else free run.
// - A two-bit field selects the output action on a compare 0 hit.
// - A second two-bit field selects the output action on a compare 1 hit.
// - Two bits select inverted or plain drive of the compare outputs.
// - Each output drives the waveform only while its port data bit and its wave output enable bit are both 1, else a fixed level.
// - A count read returns both bytes taken at one instant.
// - The count advances from the chosen source (div 1, 8, 32, fast) while running.
// - Compare 0 hit, compare 1 hit and overflow each raise their own interrupt.
module compare_output_timer
  import cot_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire cot_pkg::ahb_req_t ahb_req,
  output cot_pkg::ahb_rsp_t      ahb_rsp,
  output logic [1:0]             cmp_wave_q,
  output logic                   irq_q
);

  // ****************************************
  // Bus slave state
  // ****************************************
  logic        dphase_q;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic        hready_q;
  logic [31:0] hrdata_q;
  logic        take;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] wdata;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  timer_control_reg_a;
  logic [7:0]  timer_control_reg_b;
  logic [7:0]  wave_output_control_reg;
  logic [1:0]  port_data_q;
  logic [15:0] count_value_reg;
  logic [15:0] cmp0_act_q;
  logic [15:0] cmp1_act_q;
  logic [15:0] cmp0_pend_q;
  logic [15:0] cmp1_pend_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_en_q;

  // ****************************************
  // Decoded controls
  // ****************************************
  logic      count_run_bit;
  src_sel_t  src_sel;
  logic      clear_on_cmp1_select;
  lvl_act_t  cmp0_level_sel;
  lvl_act_t  cmp1_level_sel;
  logic      invert_select_a;
  logic      invert_select_b;
  logic      stop_wr;
  logic      cmp0_wr;
  logic      cmp1_wr;
  logic      ctrl_a_wr;
  logic      ctrl_b_wr;
  logic      oc_wr;
  logic      port_wr;
  logic      en_wr;
  logic      clr_wr;

  // ****************************************
  // Count machinery
  // ****************************************
  logic [4:0]  pre_q;
  logic [4:0]  pre_term;
  logic        tick;
  logic        hit0;
  logic        hit1;
  logic        ovf;
  logic        clr_hit;
  logic [2:0]  irq_set;

  // ****************************************
  // AHB-Lite slave, one wait state per transfer
  // ****************************************
  assign take  = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  assign wdata = ahb_req.hwdata;
  assign wr_en = dphase_q && !hready_q && wr_q;
  assign rd_en = dphase_q && !hready_q && !wr_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dphase_q <= 1'b0;
      wr_q     <= 1'b0;
      addr_q   <= 8'h00;
    end
    else if (take)
    begin
      dphase_q <= 1'b1;
      wr_q     <= ahb_req.hwrite;
      addr_q   <= ahb_req.haddr[7:0];
    end
    else if (hready_q)
    begin
      dphase_q <= 1'b0;
    end
  end

  // Wait state gives hrdata a flop of its own
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hready_q <= 1'b1;
    else if (take)
      hready_q <= 1'b0;
    else if (dphase_q)
      hready_q <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hrdata_q <= 32'h0000_0000;
    else if (rd_en)
    begin
      unique case (addr_q)
        CTRL_A_OFF:   hrdata_q <= {24'h00_0000, timer_control_reg_a};
        CTRL_B_OFF:   hrdata_q <= {24'h00_0000, timer_control_reg_b};
        WAVE_OC_OFF:  hrdata_q <= {24'h00_0000, wave_output_control_reg};
        COUNT_OFF:    hrdata_q <= {16'h0000, count_value_reg};
        CMP0_OFF:     hrdata_q <= {16'h0000, cmp0_act_q};
        CMP1_OFF:     hrdata_q <= {16'h0000, cmp1_act_q};
        PORT_OFF:     hrdata_q <= {30'h0000_0000, port_data_q};
        IRQ_STAT_OFF: hrdata_q <= {29'h0000_0000, irq_stat_q};
        IRQ_EN_OFF:   hrdata_q <= {29'h0000_0000, irq_en_q};
        default:      hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign ahb_rsp.hrdata    = hrdata_q;
  assign ahb_rsp.hreadyout = hready_q;
  assign ahb_rsp.hresp     = 1'b0;

  // ****************************************
  // Control registers
  // ****************************************
  assign count_run_bit        = timer_control_reg_a[RUN_BIT];
  assign src_sel              = src_sel_t'(timer_control_reg_a[SRC_LSB +: 2]);
  assign clear_on_cmp1_select = timer_control_reg_b[CLR_CMP1_BIT];
  assign cmp0_level_sel       = lvl_act_t'(timer_control_reg_b[LVL0_LSB +: 2]);
  assign cmp1_level_sel       = lvl_act_t'(timer_control_reg_b[LVL1_LSB +: 2]);
  assign invert_select_a      = wave_output_control_reg[INV_A_BIT];
  assign invert_select_b      = wave_output_control_reg[INV_B_BIT];

  // No strobe decodes the count offset, so its writes drop
  assign ctrl_a_wr = wr_en && (addr_q == CTRL_A_OFF);
  assign ctrl_b_wr = wr_en && (addr_q == CTRL_B_OFF);
  assign oc_wr     = wr_en && (addr_q == WAVE_OC_OFF);
  assign port_wr   = wr_en && (addr_q == PORT_OFF);
  assign en_wr     = wr_en && (addr_q == IRQ_EN_OFF);
  assign clr_wr    = wr_en && (addr_q == IRQ_CLR_OFF);
  assign stop_wr   = ctrl_a_wr && !wdata[RUN_BIT];
  assign cmp0_wr   = wr_en && (addr_q == CMP0_OFF);
  assign cmp1_wr   = wr_en && (addr_q == CMP1_OFF);

  // Unmapped places get no strobe either
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      timer_control_reg_a <= CTRL_RST;
    else if (ctrl_a_wr)
      timer_control_reg_a <= wdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      timer_control_reg_b <= CTRL_RST;
    else if (ctrl_b_wr)
      timer_control_reg_b <= wdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wave_output_control_reg <= CTRL_RST;
    else if (oc_wr)
      wave_output_control_reg <= wdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      port_data_q <= 2'h0;
    else if (port_wr)
      port_data_q <= wdata[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_en_q <= 3'h0;
    else if (en_wr)
      irq_en_q <= wdata[2:0];
  end

  // ****************************************
  // Count source prescaler
  // ****************************************
  // Fast oscillator is modelled as a fixed divide of clk, no second domain
  always_comb
  begin
    unique case (src_sel)
      SRC_DIV1:  pre_term = 5'h00;
      SRC_DIV8:  pre_term = DIV8_TERM;
      SRC_DIV32: pre_term = DIV32_TERM;
      SRC_FAST:  pre_term = FAST_TERM;
    endcase
  end

  assign tick = count_run_bit && (pre_q >= pre_term);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pre_q <= 5'h00;
    else if (!count_run_bit || tick)
      pre_q <= 5'h00;
    else
      pre_q <= pre_q + 5'h01;
  end

  // ****************************************
  // Counter and compare circuits
  // ****************************************
  assign hit0    = tick && (count_value_reg == cmp0_act_q);
  assign hit1    = tick && (count_value_reg == cmp1_act_q);
  assign clr_hit = hit1 && clear_on_cmp1_select;
  assign ovf     = tick && (count_value_reg == COUNT_MAX) && !clr_hit;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_value_reg <= 16'h0000;
    else if (stop_wr || !count_run_bit)
      count_value_reg <= 16'h0000;
    else if (clr_hit)
      count_value_reg <= 16'h0000;
    else if (tick)
      count_value_reg <= count_value_reg + 16'h0001;
  end

  // Pending copies hold writes made while counting
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cmp0_pend_q <= CMP_RST;
      cmp1_pend_q <= CMP_RST;
    end
    else
    begin
      if (cmp0_wr)
        cmp0_pend_q <= wdata[15:0];
      if (cmp1_wr)
        cmp1_pend_q <= wdata[15:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cmp0_act_q <= CMP_RST;
      cmp1_act_q <= CMP_RST;
    end
    else if (!count_run_bit)
    begin
      if (cmp0_wr)
        cmp0_act_q <= wdata[15:0];
      if (cmp1_wr)
        cmp1_act_q <= wdata[15:0];
    end
    else if ((ovf && !clear_on_cmp1_select) || clr_hit)
    begin
      cmp0_act_q <= cmp0_pend_q;
      cmp1_act_q <= cmp1_pend_q;
    end
  end

  // ****************************************
  // Interrupt status, enable and clear
  // ****************************************
  assign irq_set = {ovf, hit1, hit0};

  // Set beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_stat_q <= 3'h0;
    else if (clr_wr)
      irq_stat_q <= (irq_stat_q & ~wdata[2:0]) | irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_stat_q & irq_en_q);
  end

  // ****************************************
  // Waveform outputs
  // ****************************************
  wave_unit u_wave0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .hit      (hit0),
    .act      (cmp0_level_sel),
    .invert   (invert_select_a),
    .out_en   (wave_output_control_reg[OUT_EN_LSB]),
    .port_bit (port_data_q[0]),
    .pin_q    (cmp_wave_q[0])
  );

  wave_unit u_wave1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .hit      (hit1),
    .act      (cmp1_level_sel),
    .invert   (invert_select_b),
    .out_en   (wave_output_control_reg[OUT_EN_LSB + 1]),
    .port_bit (port_data_q[1]),
    .pin_q    (cmp_wave_q[1])
  );

endmodule // compare_output_timer

// File: pkg/cot_pkg.sv
package cot_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_A_OFF   = 8'h00;
  localparam logic [7:0] CTRL_B_OFF   = 8'h04;
  localparam logic [7:0] WAVE_OC_OFF  = 8'h08;
  localparam logic [7:0] COUNT_OFF    = 8'h0c;
  localparam logic [7:0] CMP0_OFF     = 8'h10;
  localparam logic [7:0] CMP1_OFF     = 8'h14;
  localparam logic [7:0] PORT_OFF     = 8'h18;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h1c;
  localparam logic [7:0] IRQ_EN_OFF   = 8'h20;
  localparam logic [7:0] IRQ_CLR_OFF  = 8'h24;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RUN_BIT      = 0;
  localparam int SRC_LSB      = 1;
  localparam int CLR_CMP1_BIT = 0;
  localparam int LVL0_LSB     = 4;
  localparam int LVL1_LSB     = 6;
  localparam int OUT_EN_LSB   = 0;
  localparam int INV_A_BIT    = 6;
  localparam int INV_B_BIT    = 7;
  localparam int IRQ_CMP0_BIT = 0;
  localparam int IRQ_CMP1_BIT = 1;
  localparam int IRQ_OVF_BIT  = 2;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] CMP_RST   = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [1:0]  FIXED_LVL = 2'h0;

  typedef enum logic [1:0] {
    SRC_DIV1 = 2'h0,
    SRC_DIV8 = 2'h1,
    SRC_DIV32 = 2'h2,
    SRC_FAST = 2'h3
  } src_sel_t;

  typedef enum logic [1:0] {
    LVL_HOLD   = 2'h0,
    LVL_TOGGLE = 2'h1,
    LVL_LOW    = 2'h2,
    LVL_HIGH   = 2'h3
  } lvl_act_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int FAST_OSC_NS   = 20;
  localparam logic [4:0] DIV8_TERM  = 5'h07;
  localparam logic [4:0] DIV32_TERM = 5'h1f;
  localparam logic [4:0] FAST_TERM  = 5'((FAST_OSC_NS / CLK_PERIOD_NS) - 1);

  // ****************************************
  // Bus carriers
  // ****************************************
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;

endpackage

// File: design/wave_unit.sv
`timescale 1ns/100ps
module wave_unit
  import cot_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            hit,
  input  wire cot_pkg::lvl_act_t act,
  input  wire logic            invert,
  input  wire logic            out_en,
  input  wire logic            port_bit,
  output logic                 pin_q
);

  logic level_q;
  logic level_d;

  always_comb
  begin
    level_d = level_q;
    if (hit)
    begin
      unique case (act)
        LVL_HOLD:   level_d = level_q;
        LVL_TOGGLE: level_d = ~level_q;
        LVL_LOW:    level_d = 1'b0;
        LVL_HIGH:   level_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      level_q <= 1'b0;
    else
      level_q <= level_d;
  end

  // Pin follows the new level at the hit edge itself
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pin_q <= FIXED_LVL[0];
    else if (port_bit && out_en)
      pin_q <= level_d ^ invert;
    else
      pin_q <= FIXED_LVL[0];
  end

endmodule // wave_unit

// File: sim/compare_output_timer_assertions.sv
`timescale 1ns/100ps
module compare_output_timer_checker
  import cot_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire cot_pkg::ahb_req_t ahb_req,
  input wire cot_pkg::ahb_rsp_t ahb_rsp,
  input wire logic [1:0]        cmp_wave_q,
  input wire logic              irq_q
);
  logic       pend_q;
  logic       wr_q;
  logic [7:0] adr_q;
  logic [7:0] oc_q;
  logic [1:0] port_q;
  logic [2:0] en_q;
  logic       run_q;
  logic       take;
  logic       done;
  logic       rd_done;

  assign take    = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
  assign done    = pend_q & ahb_rsp.hreadyout;
  assign rd_done = done & !wr_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pend_q <= 1'b0;
    else if (take)
      pend_q <= 1'b1;
    else if (done)
      pend_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (take)
    begin
      wr_q  <= ahb_req.hwrite;
      adr_q <= ahb_req.haddr[7:0];
    end
  end

  // Shadow lands on the same edge as the slave's own write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      {oc_q, port_q, en_q, run_q} <= '0;
    else if (pend_q & !ahb_rsp.hreadyout & wr_q)
    begin
      if (adr_q == WAVE_OC_OFF)
        oc_q <= ahb_req.hwdata[7:0];
      if (adr_q == PORT_OFF)
        port_q <= ahb_req.hwdata[1:0];
      if (adr_q == IRQ_EN_OFF)
        en_q <= ahb_req.hwdata[2:0];
      if (adr_q == CTRL_A_OFF)
        run_q <= ahb_req.hwdata[0];
    end
  end

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_okay; ahb_rsp.hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_wait; take |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_low; !ahb_rsp.hreadyout |=> ahb_rsp.hreadyout; endproperty
  a_low: assert property (p_low) else $error("ready low too long");
  property p_idle; !pend_q |-> ahb_rsp.hreadyout; endproperty
  a_idle: assert property (p_idle) else $error("ready low while idle");
  property p_cnt_stop;
    rd_done && adr_q == COUNT_OFF && !run_q |-> ahb_rsp.hrdata == 32'h0;
  endproperty
  a_cnt_stop: assert property (p_cnt_stop) else $error("count not zero when stopped");
  property p_wo_rd;
    rd_done && (adr_q == IRQ_CLR_OFF || adr_q >= 8'h28) |-> ahb_rsp.hrdata == 32'h0;
  endproperty
  a_wo_rd: assert property (p_wo_rd) else $error("unreadable place gave data");
  property p_gate0; !(oc_q[0] & port_q[0]) && $past(!(oc_q[0] & port_q[0])) |-> !cmp_wave_q[0];
  endproperty
  a_gate0: assert property (p_gate0) else $error("out0 driven while gated");
  property p_gate1; !(oc_q[1] & port_q[1]) && $past(!(oc_q[1] & port_q[1])) |-> !cmp_wave_q[1];
  endproperty
  a_gate1: assert property (p_gate1) else $error("out1 driven while gated");
  property p_mask; en_q == 3'h0 && $past(en_q) == 3'h0 |-> !irq_q; endproperty
  a_mask: assert property (p_mask) else $error("irq with all sources masked");
endmodule // compare_output_timer_checker

bind compare_output_timer compare_output_timer_checker u_chk
(
  .clk        (clk),
  .rst_n      (rst_n),
  .ahb_req    (ahb_req),
  .ahb_rsp    (ahb_rsp),
  .cmp_wave_q (cmp_wave_q),
  .irq_q      (irq_q)
);

// File: sim/compare_output_timer_bench.sv
`timescale 1ns/100ps
module compare_output_timer_bench;
  import cot_pkg::*;
  logic        clk;
  logic        rst_n;
  ahb_req_t    m;
  ahb_req_t    req;
  ahb_rsp_t    rsp;
  logic [1:0]  wave;
  logic        irq;
  logic [31:0] d;
  logic        v;
  int          error_cnt = 0;
  int          compares = 0;

  compare_output_timer dut
  (
    .clk        (clk),
    .rst_n      (rst_n),
    .ahb_req    (req),
    .ahb_rsp    (rsp),
    .cmp_wave_q (wave),
    .irq_q      (irq)
  );

  always_comb
  begin
    req        = m;
    req.hready = rsp.hreadyout;
  end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask

  // ****************
  // Bus master
  // ****************
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    m.hsel   <= 1'b1;
    m.haddr  <= {24'h0, a};
    m.htrans <= 2'h2;
    m.hwrite <= w;
    @(posedge clk);
    while (rsp.hreadyout !== 1'b1)
      @(posedge clk);
    m.hsel   <= 1'b0;
    m.htrans <= 2'h0;
    m.hwdata <= wd;
    @(posedge clk);
    while (rsp.hreadyout !== 1'b1)
      @(posedge clk);
    d = rsp.hrdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_regs();
    logic [7:0] adr [11] = '{CTRL_A_OFF, CTRL_B_OFF, WAVE_OC_OFF, COUNT_OFF, CMP0_OFF,
      CMP1_OFF, PORT_OFF, IRQ_STAT_OFF, IRQ_EN_OFF, IRQ_CLR_OFF, 8'h40};
    foreach (adr[i])
    begin
      bus(adr[i], 1'b0, 32'h0);
      check("reset_value", d, 32'h0);
    end
    bus(CMP0_OFF, 1'b1, 32'h1234);
    bus(CMP0_OFF, 1'b0, 32'h0);
    check("cmp0_stopped", d, 32'h1234);
    bus(COUNT_OFF, 1'b1, 32'h55);
    bus(COUNT_OFF, 1'b0, 32'h0);
    check("count_ro", d, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_src();
    int dv [4] = '{1, 8, 32, int'(FAST_TERM) + 1};
    for (int s = 0; s < 4; s++)
    begin
      bus(CTRL_A_OFF, 1'b1, 32'(s * 2 + 1));
      cyc(320);
      bus(COUNT_OFF, 1'b0, 32'h0);
      check("count_rate", 32'(d >= 320 / dv[s] && d <= 320 / dv[s] + 5), 32'h1);
      bus(CTRL_A_OFF, 1'b1, 32'h0);
      bus(COUNT_OFF, 1'b0, 32'h0);
      check("count_stop", d, 32'h0);
    end
    $display("test sources done");
  endtask

  task automatic t_clear();
    bus(CMP1_OFF, 1'b1, 32'd200);
    bus(CTRL_B_OFF, 1'b1, 32'h1);
    bus(CTRL_A_OFF, 1'b1, 32'h1);
    bus(CMP1_OFF, 1'b1, 32'd100);
    bus(CMP1_OFF, 1'b0, 32'h0);
    check("cmp1_pending", d, 32'd200);
    cyc(250);
    bus(CMP1_OFF, 1'b0, 32'h0);
    check("cmp1_loaded", d, 32'd100);
    bus(COUNT_OFF, 1'b1, 32'h8000);
    bus(COUNT_OFF, 1'b0, 32'h0);
    check("count_cleared", 32'(d <= 32'd100), 32'h1);
    bus(CTRL_A_OFF, 1'b1, 32'h0);
    $display("test clear done");
  endtask

  task automatic t_wave();
    bus(CMP0_OFF, 1'b1, 32'd5);
    bus(CMP1_OFF, 1'b1, 32'd19);
    bus(CTRL_B_OFF, 1'b1, 32'hd1);
    bus(WAVE_OC_OFF, 1'b1, 32'h3);
    bus(PORT_OFF, 1'b1, 32'h3);
    bus(CTRL_A_OFF, 1'b1, 32'h1);
    cyc(30);
    check("out1_high", wave[1], 1'b1);
    v = wave[0];
    cyc(20);
    check("out0_toggle", wave[0], !v);
    bus(WAVE_OC_OFF, 1'b1, 32'h83);
    cyc(2);
    check("out1_invert", wave[1], 1'b0);
    bus(WAVE_OC_OFF, 1'b1, 32'h3);
    cyc(2);
    check("out1_plain", wave[1], 1'b1);
    bus(PORT_OFF, 1'b1, 32'h1);
    cyc(2);
    check("out1_port", wave[1], 1'b0);
    bus(CTRL_B_OFF, 1'b1, 32'hf1);
    cyc(25);
    check("out0_high", wave[0], 1'b1);
    bus(CTRL_B_OFF, 1'b1, 32'he1);
    cyc(25);
    check("out0_low", wave[0], 1'b0);
    bus(CTRL_B_OFF, 1'b1, 32'hc1);
    bus(WAVE_OC_OFF, 1'b1, 32'h41);
    cyc(25);
    check("out0_hold_inv", wave[0], 1'b1);
    bus(CTRL_A_OFF, 1'b1, 32'h0);
    $display("test wave done");
  endtask

  task automatic t_free();
    bus(CTRL_B_OFF, 1'b1, 32'h0);
    bus(CMP0_OFF, 1'b1, 32'd50);
    bus(IRQ_CLR_OFF, 1'b1, 32'h7);
    bus(IRQ_EN_OFF, 1'b1, 32'h1);
    bus(CTRL_A_OFF, 1'b1, 32'h1);
    bus(CMP0_OFF, 1'b1, 32'd60);
    bus(CMP0_OFF, 1'b0, 32'h0);
    check("cmp0_pending", d, 32'd50);
    cyc(60);
    check("irq_cmp0", irq, 1'b1);
    bus(IRQ_STAT_OFF, 1'b0, 32'h0);
    check("stat_cmp0", d[0], 1'b1);
    bus(CMP0_OFF, 1'b0, 32'h0);
    check("cmp0_held", d, 32'd50);
    bus(IRQ_CLR_OFF, 1'b1, 32'h1);
    cyc(1);
    check("irq_cleared", irq, 1'b0);
    bus(IRQ_EN_OFF, 1'b1, 32'h4);
    cyc(66000);
    check("irq_ovf", irq, 1'b1);
    bus(CMP0_OFF, 1'b0, 32'h0);
    check("cmp0_loaded", d, 32'd60);
    bus(IRQ_EN_OFF, 1'b1, 32'h0);
    cyc(1);
    check("irq_masked", irq, 1'b0);
    bus(IRQ_STAT_OFF, 1'b0, 32'h0);
    check("stat_ovf", d[2], 1'b1);
    bus(CTRL_A_OFF, 1'b1, 32'h0);
    $display("test free run done");
  endtask

  // Overflow wait dominates the run
  initial
  begin
    #500000;
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    m = '0;
    m.hsize = 3'h2;
    rst_n = 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(1);
    t_regs();
    t_src();
    t_clear();
    t_wave();
    t_free();
    give_verdict();
  end
endmodule // compare_output_timer_bench
